//--- logic/pnlmon_pkg.sv
// Purpose: Shared constants for the panel monitor display block
// Assumes: 100 MHz ref_clk, APB register access with 32-bit data
// Notes:   Values shown as numbers are held by software as BCD digits
`default_nettype none
package pnlmon_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;            // Clock rate
  localparam int KEY_HOLD_MS  = 1000;                   // Long press time
  localparam int KEY_HOLD_CYC = KEY_HOLD_MS * (CLK_HZ / 1000);
  localparam int KEY_DEB_MS   = 10;                     // Key settle time
  localparam int KEY_DEB_CYC  = KEY_DEB_MS * (CLK_HZ / 1000);
  localparam int KEY_CNT_W    = 27;                     // Fits the hold count

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;  // Calc method select
  localparam logic [11:0] OFS_SPEED   = 12'h004;  // Motor speed, BCD
  localparam logic [11:0] OFS_RES_LIM = 12'h008;  // Resolution limit, BCD
  localparam logic [11:0] OFS_SPD_LIM = 12'h00C;  // Speed limit mm/s, BCD
  localparam logic [11:0] OFS_STATUS  = 12'h010;  // Panel state, read only
  localparam int          CTRL_CALC   = 0;        // Calc method bit
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [19:0] VALUE_RST   = 20'h0_0000;
  localparam int          STAT_ITEM   = 0;        // Item index field [2:0]
  localparam int          STAT_STATE  = 4;        // State field [6:4]
  localparam int          STAT_POLE   = 8;        // Pole code field [10:8]

  // ----------------------------------------------------------------
  // Monitor items
  // ----------------------------------------------------------------
  localparam int          NUM_ITEMS = 6;
  localparam logic [2:0]  IX_SPEED  = 3'h0;  // motor_speed_item
  localparam logic [2:0]  IX_IN     = 3'h1;  // input_bits_item
  localparam logic [2:0]  IX_OUT    = 3'h2;  // output_bits_item
  localparam logic [2:0]  IX_LIM    = 3'h3;  // limit_calc_item
  localparam logic [2:0]  IX_POLE   = 3'h4;  // pole_pattern_item
  localparam logic [2:0]  IX_SAFE   = 3'h5;  // safety_bits_item
  localparam logic [2:0]  IX_LAST   = 3'h5;
  // Item numbers as three BCD digits
  localparam logic [11:0] ITEM_NUM [NUM_ITEMS] = '{12'h000, 12'h005, 12'h006,
                                                   12'h010, 12'h011, 12'h015};
  localparam logic [7:0]  IN_VALID   = 8'hFF;  // All eight digits used
  localparam logic [7:0]  OUT_VALID  = 8'h7F;  // Digit 8 reserved
  localparam logic [7:0]  SAFE_VALID = 8'h03;  // Digits 3 to 8 reserved

  // ----------------------------------------------------------------
  // Segments: bit 7 dp, 6 g, 5 f, 4 e, 3 d, 2 c, 1 b, 0 a
  // ----------------------------------------------------------------
  localparam int         NUM_POS   = 5;
  localparam logic [7:0] SEG_U     = 8'h3E;
  localparam logic [7:0] SEG_DASH  = 8'h40;
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam int         SEG_B     = 1;  // Right half, top
  localparam int         SEG_C     = 2;  // Right half, bottom
  localparam int         SEG_E     = 4;  // Left half, bottom
  localparam int         SEG_F     = 5;  // Left half, top

  typedef enum logic [2:0] {
    ST_STATUS = 3'b001,  // Not in monitor mode
    ST_ITEM   = 3'b010,  // Showing item number
    ST_DATA   = 3'b100   // Showing item contents
  } pnlmon_state_t;
endpackage
`default_nettype wire

//--- logic/pnlmon_key.sv
// Purpose: One panel key: synchroniser, debounce, press and long hold
// Assumes: Key pin high while pressed, asynchronous to ref_clk
// Notes:   Hold fires once per press, after the hold count
`timescale 1ns/10ps
`default_nettype none
module pnlmon_key
  import pnlmon_pkg::*;
#(
  parameter int HOLD_CYC = KEY_HOLD_CYC,
  parameter int DEB_CYC  = KEY_DEB_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic key_pin,   // Raw key level
  output var  logic press,     // One cycle on debounced press
  output var  logic hold       // One cycle after long hold
);
  logic                 sync1_reg;   // First stage, read by stage two only
  logic                 sync2_reg;   // Safe level
  logic                 stable_reg;  // Debounced level
  logic [KEY_CNT_W-1:0] deb_reg;     // Settle counter
  logic [KEY_CNT_W-1:0] hold_reg;    // Held-time counter

  // ----------------------------------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= key_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Debounce: level must hold for the settle count before it counts
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deb_reg    <= '0;
      stable_reg <= 1'b0;
      press      <= 1'b0;
    end else begin
      press <= 1'b0;
      if (sync2_reg == stable_reg) begin
        deb_reg <= '0;
      end else if (deb_reg >= KEY_CNT_W'(DEB_CYC - 1)) begin
        // Bounce over: take the new level
        deb_reg    <= '0;
        stable_reg <= sync2_reg;
        press      <= sync2_reg;
      end else begin
        deb_reg <= deb_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Long hold: counter saturates so the pulse cannot repeat
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= '0;
      hold     <= 1'b0;
    end else begin
      hold <= 1'b0;
      if (!stable_reg) begin
        hold_reg <= '0;
      end else if (hold_reg < KEY_CNT_W'(HOLD_CYC)) begin
        hold_reg <= hold_reg + 1'b1;
        hold     <= (hold_reg == KEY_CNT_W'(HOLD_CYC - 1));
      end
    end
  end
endmodule // pnlmon_key
`default_nettype wire

//--- logic/pnlmon_top.sv
// Purpose: Front panel monitor display mode with APB register access
// Assumes: Input pins high when the input circuit is closed; output
//          monitor levels come from same-clock logic, high = conducting
// Notes:   Five positions; bit monitors put two digits on each of positions 4 to 1
//
// How it works
// R1: Mode key enters monitor mode, item shown
// R2: Up/down step the selected item number
// R3: Long data press toggles number and contents
// R4: Input monitor: off top segment, on bottom
// R5: Input digits follow the fixed eight-signal order
// R6: Closed input circuit counts as on
// R7: Output monitor: off top segment, on bottom
// R8: Output digits: alarm, three outputs, alarm code
// R9: Conducting output transistor counts as on
// R10: Safety monitor inverted: on top, off bottom
// R11: Safety digits one and two, rest reserved
// R12: Calc method field picks which limit shows
// R13: Method one shows speed limit in mm/s
// R14: Long data press shows pole pattern
// R15: Pole code is U,V,W bits, high one
// R16: Values shown on five segment positions
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pnlmon_top
  import pnlmon_pkg::*;
#(
  parameter int HOLD_CYC = KEY_HOLD_CYC,  // Long press, in cycles
  parameter int DEB_CYC  = KEY_DEB_CYC    // Key settle, in cycles
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Panel keys, high while pressed
  input  wire logic        key_mode,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_data,
  // Monitored input pins, high when closed
  input  wire logic        general_input_0,
  input  wire logic        general_input_1,
  input  wire logic        general_input_2,
  input  wire logic        general_input_3,
  input  wire logic        general_input_4,
  input  wire logic        general_input_5,
  input  wire logic        general_input_6,
  input  wire logic        encoder_sensor_on_input,
  input  wire logic        safety_block_input_1,
  input  wire logic        safety_block_input_2,
  input  wire logic        pole_u,
  input  wire logic        pole_v,
  input  wire logic        pole_w,
  // Output states from drive logic, high when conducting
  input  wire logic        alarm_output,
  input  wire logic        general_output_1,
  input  wire logic        general_output_2,
  input  wire logic        general_output_3,
  input  wire logic        alarm_code_bit_1,
  input  wire logic        alarm_code_bit_2,
  input  wire logic        alarm_code_bit_3,
  // Display: position 4 leftmost, 8 segments each
  output var  logic [39:0] disp_seg
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NPIN = 13;
  logic [NPIN-1:0] pin_vec;         // Raw pins
  logic [NPIN-1:0] sync1_reg;       // First stage, read by stage two only
  logic [NPIN-1:0] sync2_reg;       // Safe levels
  logic [7:0]      in_on;           // Input digits 1..8 as bit 0..7
  logic [7:0]      out_on;          // Output digits 1..8
  logic [7:0]      safe_on;         // Safety digits 1..8
  logic [2:0]      pole_code;       // U msb, W lsb
  logic [3:0]      press;           // Mode, up, down, data
  logic [3:0]      hold;
  logic [3:0]      key_raw;
  pnlmon_state_t   st_reg;          // Panel state
  logic [2:0]      item_reg;        // Selected item index
  logic            calc_reg;        // calc_method_field
  logic [19:0]     speed_reg;       // Motor speed value, BCD
  logic [19:0]     res_lim_reg;     // Resolution limit, BCD
  logic [19:0]     spd_lim_reg;     // Speed limit in mm/s, BCD
  logic [39:0]     disp_next;       // Display image for next cycle
  logic            apb_done;        // Access phase completes now
  logic            apb_map;         // Address decodes to a register

  // ----------------------------------------------------------------
  // Segment helpers
  // ----------------------------------------------------------------
  // Hex digit to segment pattern
  function automatic logic [7:0] seg_of(input logic [3:0] d);
    unique case (d)
      4'h0: seg_of = 8'h3F;
      4'h1: seg_of = 8'h06;
      4'h2: seg_of = 8'h5B;
      4'h3: seg_of = 8'h4F;
      4'h4: seg_of = 8'h66;
      4'h5: seg_of = 8'h6D;
      4'h6: seg_of = 8'h7D;
      4'h7: seg_of = 8'h07;
      4'h8: seg_of = 8'h7F;
      4'h9: seg_of = 8'h6F;
      4'hA: seg_of = 8'h77;
      4'hB: seg_of = 8'h7C;
      4'hC: seg_of = 8'h39;
      4'hD: seg_of = 8'h5E;
      4'hE: seg_of = 8'h79;
      4'hF: seg_of = 8'h71;
    endcase
  endfunction

  // Bit monitor image: digit k on position 4-k/2, left half first.
  // Unused digits stay dark so reserved slots are visibly empty.
  function automatic logic [39:0] bits_img(input logic [7:0] on,
                                           input logic [7:0] valid,
                                           input logic       inv);
    logic [39:0] img;
    logic        top;
    img = '0;
    for (int k = 0; k < 8; k++) begin
      top = inv ? on[k] : !on[k];
      if (valid[k]) begin
        if (k[0] == 1'b0) begin
          img[(4 - k / 2) * 8 + SEG_F] = top;
          img[(4 - k / 2) * 8 + SEG_E] = !top;
        end else begin
          img[(4 - k / 2) * 8 + SEG_B] = top;
          img[(4 - k / 2) * 8 + SEG_C] = !top;
        end
      end
    end
    bits_img = img;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  assign pin_vec = {pole_u, pole_v, pole_w,
                    safety_block_input_2, safety_block_input_1,
                    encoder_sensor_on_input, general_input_6,
                    general_input_5, general_input_4, general_input_2,
                    general_input_1, general_input_3, general_input_0};

  // Two stages before any logic reads a pin in pin_vec
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
    end
  end

  // Closed circuit reads high, so a high level is on
  assign in_on     = sync2_reg[7:0];                  // R5 R6
  assign safe_on   = {6'h00, sync2_reg[9:8]};         // R11
  assign pole_code = sync2_reg[12:10];                // R15
  // Conducting transistor is a high level from drive logic
  assign out_on    = {1'b0, alarm_code_bit_3, alarm_code_bit_2,
                      alarm_code_bit_1, general_output_3, general_output_2,
                      general_output_1, alarm_output}; // R8 R9

  // ----------------------------------------------------------------
  // Keys
  // ----------------------------------------------------------------
  assign key_raw = {key_data, key_down, key_up, key_mode};

  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++) begin : g_key
      pnlmon_key #(
        .HOLD_CYC (HOLD_CYC),
        .DEB_CYC  (DEB_CYC)
      ) u_key (
        .ref_clk (ref_clk),
        .rst     (rst),
        .key_pin (key_raw[gk]),
        .press   (press[gk]),
        .hold    (hold[gk])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Panel state: mode key wins over the others in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_STATUS;
    end else begin
      unique case (st_reg)
        ST_STATUS: begin
          if (press[0]) st_reg <= ST_ITEM;                   // R1
        end
        ST_ITEM: begin
          // Mode key leaves toward modes this block does not show
          if (press[0]) st_reg <= ST_STATUS;
          else if (hold[3]) st_reg <= ST_DATA;               // R3 R14
        end
        ST_DATA: begin
          if (press[0]) st_reg <= ST_STATUS;
          else if (hold[3]) st_reg <= ST_ITEM;               // R3
        end
        default: st_reg <= ST_STATUS;
      endcase
    end
  end

  // Item selection wraps at both ends
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      item_reg <= IX_SPEED;
    end else if (st_reg == ST_ITEM && !press[0] && !hold[3]) begin
      if (press[1]) begin
        item_reg <= (item_reg == IX_LAST) ? IX_SPEED : item_reg + 3'h1; // R2
      end else if (press[2]) begin
        item_reg <= (item_reg == IX_SPEED) ? IX_LAST : item_reg - 3'h1; // R2
      end
    end
  end

  // ----------------------------------------------------------------
  // Display image
  // ----------------------------------------------------------------
  always_comb begin
    disp_next = {5{SEG_BLANK}};
    unique case (st_reg)
      ST_ITEM: begin
        // Item number as U-nnn
        disp_next = {SEG_U, SEG_DASH, seg_of(ITEM_NUM[item_reg][11:8]),
                     seg_of(ITEM_NUM[item_reg][7:4]),
                     seg_of(ITEM_NUM[item_reg][3:0])};        // R1 R2
      end
      ST_DATA: begin
        if (item_reg == IX_IN) begin
          disp_next = bits_img(in_on, IN_VALID, 1'b0);        // R4
        end else if (item_reg == IX_OUT) begin
          disp_next = bits_img(out_on, OUT_VALID, 1'b0);      // R7
        end else if (item_reg == IX_SAFE) begin
          disp_next = bits_img(safe_on, SAFE_VALID, 1'b1);    // R10
        end else if (item_reg == IX_POLE) begin
          disp_next[7:0] = seg_of({1'b0, pole_code});         // R14 R15
        end else begin
          // Numeric values fill the five positions
          for (int p = 0; p < NUM_POS; p++) begin
            if (item_reg == IX_LIM) begin
              disp_next[p*8 +: 8] = calc_reg ? seg_of(spd_lim_reg[p*4 +: 4])
                                             : seg_of(res_lim_reg[p*4 +: 4]); // R12 R13
            end else begin
              disp_next[p*8 +: 8] = seg_of(speed_reg[p*4 +: 4]); // R16
            end
          end
        end
      end
      default: disp_next = {5{SEG_BLANK}};
    endcase
  end

  // Display output registered to keep segment lines glitch free
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) disp_seg <= '0;
    else     disp_seg <= disp_next;                         // R16
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state so read data comes from a flop
  // ----------------------------------------------------------------
  assign apb_done = psel && penable && pready;
  assign apb_map  = (paddr == OFS_CTRL) || (paddr == OFS_SPEED) ||
                    (paddr == OFS_RES_LIM) || (paddr == OFS_SPD_LIM) ||
                    (paddr == OFS_STATUS);

  // Answer: ready, read data and error rise in the second access cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !apb_map;
      prdata  <= '0;
      if (!pwrite) begin
        unique case (paddr)
          OFS_CTRL:    prdata[CTRL_CALC] <= calc_reg;
          OFS_SPEED:   prdata[19:0] <= speed_reg;
          OFS_RES_LIM: prdata[19:0] <= res_lim_reg;
          OFS_SPD_LIM: prdata[19:0] <= spd_lim_reg;
          OFS_STATUS: begin
            prdata[STAT_ITEM +: 3]  <= item_reg;
            prdata[STAT_STATE +: 3] <= st_reg;
            prdata[STAT_POLE +: 3]  <= pole_code;
          end
          default: prdata <= '0;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writes take effect at the completing edge only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      calc_reg    <= CTRL_RST[CTRL_CALC];
      speed_reg   <= VALUE_RST;
      res_lim_reg <= VALUE_RST;
      spd_lim_reg <= VALUE_RST;
    end else if (apb_done && pwrite) begin
      if (paddr == OFS_CTRL)    calc_reg    <= pwdata[CTRL_CALC]; // R12
      if (paddr == OFS_SPEED)   speed_reg   <= pwdata[19:0];
      if (paddr == OFS_RES_LIM) res_lim_reg <= pwdata[19:0];
      if (paddr == OFS_SPD_LIM) spd_lim_reg <= pwdata[19:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_mode_enter: assert property (@(posedge ref_clk) disable iff (rst) // R1
    (st_reg == ST_STATUS && press[0]) |=> (st_reg == ST_ITEM) ##1
      (disp_seg[39:32] == SEG_U))
    else $error("mode key did not open item display");

  a_item_step: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (st_reg == ST_ITEM && press[1] && !press[0] && !hold[3] && item_reg != IX_LAST)
      |=> item_reg == $past(item_reg) + 3'h1)
    else $error("up key did not step item");

  a_data_toggle: assert property (@(posedge ref_clk) disable iff (rst) // R3
    (st_reg == ST_DATA && hold[3] && !press[0]) |=> st_reg == ST_ITEM)
    else $error("long data press did not return to item");

  a_in_bits: assert property (@(posedge ref_clk) disable iff (rst) // R4
    (st_reg == ST_DATA && item_reg == IX_IN) |=>
      (disp_seg[32+SEG_F] == !$past(general_input_0, 3)) &&
      (disp_seg[32+SEG_E] == $past(general_input_0, 3)))
    else $error("input digit one wrong");

  a_in_order: assert property (@(posedge ref_clk) disable iff (rst) // R5
    (st_reg == ST_DATA && item_reg == IX_IN) |=>
      disp_seg[32+SEG_C] == $past(general_input_3, 3) &&
      disp_seg[8+SEG_C] == $past(encoder_sensor_on_input, 3))
    else $error("input digit order wrong");

  a_out_bits: assert property (@(posedge ref_clk) disable iff (rst) // R7
    (st_reg == ST_DATA && item_reg == IX_OUT) |=>
      disp_seg[32+SEG_F] == !$past(alarm_output) &&
      disp_seg[8+SEG_F] == !$past(alarm_code_bit_3) &&
      disp_seg[8+SEG_B] == 1'b0 && disp_seg[8+SEG_C] == 1'b0)
    else $error("output digits wrong");

  a_safe_inv: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (st_reg == ST_DATA && item_reg == IX_SAFE) |=>
      disp_seg[32+SEG_F] == $past(safety_block_input_1, 3) &&
      disp_seg[32+SEG_C] == !$past(safety_block_input_2, 3) &&
      disp_seg[31:0] == '0)
    else $error("safety digits wrong");

  a_limit_sel: assert property (@(posedge ref_clk) disable iff (rst) // R12
    (st_reg == ST_DATA && item_reg == IX_LIM && calc_reg) |=>
      disp_seg[7:0] == seg_of($past(spd_lim_reg[3:0])))
    else $error("limit select wrong");

  a_pole_code: assert property (@(posedge ref_clk) disable iff (rst) // R15
    (st_reg == ST_DATA && item_reg == IX_POLE) |=>
      disp_seg[7:0] == seg_of({1'b0, $past(pole_u, 3), $past(pole_v, 3),
                               $past(pole_w, 3)}))
    else $error("pole code wrong");

  a_apb_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule // pnlmon_top
`default_nettype wire

//--- tb/pnlmon_panel_model.sv
// Purpose: Operator pressing the four panel keys
// Assumes: Keys read high while pressed
// Notes:   Idle gap after release lets debounce settle
`timescale 1ns/10ps
`default_nettype none
module pnlmon_panel_model (
  input  wire logic       ref_clk,
  output var  logic [3:0] keys     // Mode, up, down, data
);
  initial keys = 4'h0;
  // Hold key k for n cycles, then leave the panel alone
  task push(input int k, input int n);
    @(posedge ref_clk) keys[k] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    keys[k] <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule // pnlmon_panel_model
`default_nettype wire

//--- tb/pnlmon_top_tb.sv
// Purpose: Self-checking bench for the panel monitor
// Assumes: Short hold and settle counts
// Notes:   Speed limit is read back; both limit values are checked on the display
`timescale 1ns/10ps
`default_nettype none
module pnlmon_top_tb
  import pnlmon_pkg::*;
;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  keys;
  logic [7:0]  din, dout;  // Levels in display digit order
  logic [2:0]  pol;        // U, V, W
  logic [1:0]  saf;
  logic [39:0] disp_seg;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  // Segment images of digits 0 to 7, bit 0 is segment a
  localparam logic [7:0] SEGS [8] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  pnlmon_top #(.HOLD_CYC(20), .DEB_CYC(3)) pnlmon_top_i (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_mode(keys[0]), .key_up(keys[1]), .key_down(keys[2]), .key_data(keys[3]),
    .general_input_0(din[0]), .general_input_3(din[1]), .general_input_1(din[2]),
    .general_input_2(din[3]), .general_input_4(din[4]), .general_input_5(din[5]),
    .general_input_6(din[6]), .encoder_sensor_on_input(din[7]),
    .safety_block_input_1(saf[0]), .safety_block_input_2(saf[1]),
    .pole_u(pol[2]), .pole_v(pol[1]), .pole_w(pol[0]),
    .alarm_output(dout[0]), .general_output_1(dout[1]), .general_output_2(dout[2]),
    .general_output_3(dout[3]), .alarm_code_bit_1(dout[4]), .alarm_code_bit_2(dout[5]),
    .alarm_code_bit_3(dout[6]), .disp_seg(disp_seg));
  pnlmon_panel_model pnlmon_panel_model_i (.ref_clk(ref_clk), .keys(keys));
  task check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // APB master: request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task status(input logic [2:0] st, input logic [2:0] ix);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check({33'h0, err, rd[6:4], rd[2:0]}, {33'h0, 1'b0, st, ix});
  endtask
  // Expected bit monitor: odd digits left half, even digits right half
  function logic [39:0] bits(logic [7:0] on, logic [7:0] vld, logic inv);
    logic [39:0] e;
    e = '0;
    for (int k = 0; k < 8; k++) begin
      if (vld[k]) begin
        if (k % 2 == 0) e[(4 - k / 2) * 8 + ((on[k] ^ inv) ? SEG_E : SEG_F)] = 1'b1;
        else e[(4 - k / 2) * 8 + ((on[k] ^ inv) ? SEG_C : SEG_B)] = 1'b1;
      end
    end
    return e;
  endfunction
  // Show a bit monitor's contents for two level patterns, then go back
  task mon(input logic [2:0] ix, input logic [7:0] p, input logic [7:0] vld, input logic inv);
    pnlmon_panel_model_i.push(3, 40);
    status(3'b100, ix);
    for (int i = 0; i < 2; i++) begin
      din <= p;
      dout <= p;
      saf <= p[1:0];
      repeat (6) @(posedge ref_clk);
      check(disp_seg, bits(p, vld, inv));
      p = ~p;
    end
    pnlmon_panel_model_i.push(3, 40);
    status(3'b010, ix);
    pnlmon_panel_model_i.push(1, 8);
  endtask
  task t_nav;
    pnlmon_panel_model_i.push(0, 8);
    status(3'b010, IX_SPEED);
    check({24'h0, disp_seg[39:24]}, {24'h0, SEG_U, SEG_DASH});
    pnlmon_panel_model_i.push(2, 8);
    status(3'b010, IX_LAST);
    pnlmon_panel_model_i.push(1, 8);
    pnlmon_panel_model_i.push(1, 8);
    status(3'b010, IX_IN);
  endtask
  // Method select and limit value live in registers software writes
  task t_limit;
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_SPD_LIM, 32'h0001_2345);
    apb(1'b1, OFS_RES_LIM, 32'h0005_4321);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    check({8'h0, rd}, 40'h00_0000_0001);
    apb(1'b0, OFS_SPD_LIM, 32'h0000_0000);
    check({8'h0, rd}, 40'h00_0001_2345);
    // Limit item contents: method one shows the speed limit digits
    pnlmon_panel_model_i.push(3, 40);
    check(disp_seg, 40'h06_5B4F_666D);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check(disp_seg, 40'h6D_664F_5B06);
    // Unmapped address answers with an error and zero data
    apb(1'b0, 12'h014, 32'h0000_0000);
    check({7'h0, err, rd}, 40'h01_0000_0000);
    pnlmon_panel_model_i.push(3, 40);
    pnlmon_panel_model_i.push(1, 8);
  endtask
  task t_pole;
    pnlmon_panel_model_i.push(3, 40);
    status(3'b100, IX_POLE);
    for (int v = 0; v < 8; v++) begin
      pol <= v[2:0];
      repeat (6) @(posedge ref_clk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check({37'h0, rd[10:8]}, {37'h0, v[2:0]});
      check(disp_seg, {32'h0, SEGS[v]});
    end
    pnlmon_panel_model_i.push(3, 40);
    pnlmon_panel_model_i.push(1, 8);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {din, dout, saf, pol} = 21'h0_0000;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_nav();
    mon(IX_IN, 8'hA5, IN_VALID, 1'b0);
    mon(IX_OUT, 8'hC9, OUT_VALID, 1'b0);
    t_limit();
    t_pole();
    mon(IX_SAFE, 8'h01, SAFE_VALID, 1'b1);
    stop_test();
  end
endmodule // pnlmon_top_tb
`default_nettype wire
